// *** inc/eim_pkg.sv ***
// constants and carrier types for the event monitor and mask block
// assumes one 40 MHz system clock and an 8-bit byte register port
package eim_pkg;

  // register geometry: fifteen bytes in each bank
  localparam int          NUM_BYTES    = 15;
  localparam int          NUM_BITS     = NUM_BYTES * 8;
  localparam logic [15:0] MON_BASE     = 16'h300b;
  localparam logic [15:0] MASK_BASE    = 16'h010c;
  localparam logic [15:0] CLR_BASE     = 16'h2006;
  localparam logic [15:0] GRP_CLR_ADDR = 16'h2005;

  // byte ranges of the three groups inside each bank
  localparam int          COMMON_LO    = 0;
  localparam int          COMMON_HI    = 4;
  localparam int          FIRST_LO     = 5;
  localparam int          FIRST_HI     = 9;
  localparam int          SECOND_LO    = 10;
  localparam int          SECOND_HI    = 14;

  // group clear register bit positions
  localparam int          GC_ALL       = 0;
  localparam int          GC_COMMON    = 1;
  localparam int          GC_FIRST     = 2;
  localparam int          GC_SECOND    = 3;

  // values after reset
  localparam logic [7:0]  MASK_RST     = 8'h00;
  localparam logic [7:0]  CLR_RST      = 8'h00;
  localparam logic [7:0]  MON_RST      = 8'h00;
  localparam logic [3:0]  GRP_CLR_RST  = 4'h0;

  // synchroniser depth for inputs from other domains
  localparam int          SYNC_STAGES  = 3;

  // one register write
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
    logic [7:0]  data;
  } eim_wr_t;

  // the four status results
  typedef struct packed {
    logic any_irq;
    logic common_irq;
    logic first_pair_group_status;
    logic second_pair_group_status;
  } eim_status_t;

endpackage

// *** logic/eim_sync.sv ***
// three-stage synchroniser with agreement filter
// assumes inputs are asynchronous levels; output changes when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module eim_sync
  import eim_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire  [WIDTH-1:0] agree;
  wire  [WIDTH-1:0] next_dout;

  // meta is read only by s2, so no gate sees a metastable value
  assign agree     = ~(s2 ^ s3);
  assign next_dout = (agree & s2) | (~agree & dout);

  // capture chain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      s2   <= meta;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule
`default_nettype wire

// *** logic/eim_slice.sv ***
// one byte of sticky monitor bits
// assumes qualified events and clear strobes are already on the system clock
`timescale 1ns/10ps
`default_nettype none
module eim_slice
  import eim_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // qualified events and clear strobes
  input  wire logic [7:0] qual,
  input  wire logic [7:0] clr,
  // monitor byte and its next value
  output logic      [7:0] mon,
  output logic      [7:0] next_mon
);

  // an event in the clearing cycle survives the clear
  assign next_mon = (mon & ~clr) | qual;

  // sticky store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mon <= MON_RST;
    end else begin
      mon <= next_mon;
    end
  end

endmodule
`default_nettype wire

// *** logic/eim_top.sv ***
// event monitor, mask and clear logic with group status results
// assumes register writes and reads come from the serial port logic on the system clock;
// raw events and multifunction pin clears arrive asynchronously
`timescale 1ns/10ps
`default_nettype none
module eim_top
  import eim_pkg::*;
(
  // clock and reset
  input  wire logic                SYS_CLK,
  input  wire logic                RST_N,
  // register write port
  input  wire eim_wr_t             WR,
  // register read port, data one cycle after address
  input  wire logic [15:0]         RD_ADDR,
  output logic      [7:0]          RD_DATA,
  // raw device events, asynchronous
  input  wire logic [NUM_BITS-1:0] EVT_RAW,
  // multifunction pin clear inputs: all, common, first pair, second pair
  input  wire logic [3:0]          MF_CLR,
  // status results
  output eim_status_t              STATUS
);

  // decoding shared by write and read paths
  function automatic logic [NUM_BYTES-1:0] byte_hit(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] off;
    off      = a - base;
    byte_hit = '0;
    for (int k = 0; k < NUM_BYTES; k++) begin
      if (off == 16'(k)) begin
        byte_hit[k] = 1'b1;
      end
    end
  endfunction

  // expands four group clear bits into a per-bit clear vector
  function automatic logic [NUM_BITS-1:0] grp_vec(input logic [3:0] g);
    grp_vec = '0;
    for (int k = 0; k < NUM_BYTES; k++) begin
      if (g[GC_ALL] ||
          (g[GC_COMMON] && k >= COMMON_LO && k <= COMMON_HI) ||
          (g[GC_FIRST]  && k >= FIRST_LO  && k <= FIRST_HI)  ||
          (g[GC_SECOND] && k >= SECOND_LO && k <= SECOND_HI)) begin
        grp_vec[k*8 +: 8] = 8'hff;
      end
    end
  endfunction

  // selects one byte of a bank by one-hot select
  function automatic logic [7:0] pick(input logic [NUM_BYTES-1:0] sel, input logic [NUM_BITS-1:0] v);
    pick = 8'h00;
    for (int k = 0; k < NUM_BYTES; k++) begin
      if (sel[k]) begin
        pick = pick | v[k*8 +: 8];
      end
    end
  endfunction

  logic [NUM_BITS-1:0] mask;
  logic [NUM_BITS-1:0] clr_reg;
  logic [3:0]          grp_clr;
  logic [NUM_BITS-1:0] evt_sync;
  logic [3:0]          pin_clr;
  logic [NUM_BITS-1:0] mon;
  logic [NUM_BITS-1:0] next_mon;

  // raw events and pins cross into the system clock first
  eim_sync #(
    .WIDTH (NUM_BITS)
  ) u_evt_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   (EVT_RAW),
    .dout  (evt_sync)
  );

  eim_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .din   (MF_CLR),
    .dout  (pin_clr)
  );

  // write decode
  wire [NUM_BYTES-1:0] wr_mask_hit = WR.en ? byte_hit(WR.addr, MASK_BASE) : '0;
  wire [NUM_BYTES-1:0] wr_clr_hit  = WR.en ? byte_hit(WR.addr, CLR_BASE) : '0;
  wire                 wr_grp_hit  = WR.en && (WR.addr == GRP_CLR_ADDR);

  // qualification and the combined clear vector
  wire [NUM_BITS-1:0]  qual    = evt_sync & mask;
  wire [NUM_BITS-1:0]  clr_vec = clr_reg | grp_vec(grp_clr) | grp_vec(pin_clr);

  // per-byte mask and self-clearing clear registers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BYTES; gi++) begin : g_byte
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          mask[gi*8 +: 8] <= MASK_RST;
        end else if (wr_mask_hit[gi]) begin
          mask[gi*8 +: 8] <= WR.data;
        end
      end

      // clear bits hold for one cycle and then return to zero
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          clr_reg[gi*8 +: 8] <= CLR_RST;
        end else begin
          clr_reg[gi*8 +: 8] <= wr_clr_hit[gi] ? WR.data : CLR_RST;
        end
      end

      eim_slice u_slice (
        .clk      (SYS_CLK),
        .rst_n    (RST_N),
        .qual     (qual[gi*8 +: 8]),
        .clr      (clr_vec[gi*8 +: 8]),
        .mon      (mon[gi*8 +: 8]),
        .next_mon (next_mon[gi*8 +: 8])
      );
    end
  endgenerate

  // group clear register, self-clearing like the per-bit clears
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      grp_clr <= GRP_CLR_RST;
    end else begin
      grp_clr <= wr_grp_hit ? WR.data[3:0] : GRP_CLR_RST;
    end
  end

  // group results from the next monitor value so status lines up with the monitor flops
  wire next_common = |next_mon[COMMON_LO*8 +: (COMMON_HI-COMMON_LO+1)*8];
  wire next_first  = |next_mon[FIRST_LO*8  +: (FIRST_HI-FIRST_LO+1)*8];
  wire next_second = |next_mon[SECOND_LO*8 +: (SECOND_HI-SECOND_LO+1)*8];
  wire next_any    = |next_mon;

  // status flops; a group drops only when every bit in it is zero
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      STATUS <= '0;
    end else begin
      STATUS.any_irq                  <= next_any;
      STATUS.common_irq               <= next_common;
      STATUS.first_pair_group_status  <= next_first;
      STATUS.second_pair_group_status <= next_second;
    end
  end

  // read decode; unmapped addresses read zero
  wire [NUM_BYTES-1:0] rd_mon_hit  = byte_hit(RD_ADDR, MON_BASE);
  wire [NUM_BYTES-1:0] rd_mask_hit = byte_hit(RD_ADDR, MASK_BASE);
  wire [NUM_BYTES-1:0] rd_clr_hit  = byte_hit(RD_ADDR, CLR_BASE);
  wire [7:0]           rd_grp      = (RD_ADDR == GRP_CLR_ADDR) ? {4'h0, grp_clr} : 8'h00;
  wire [7:0]           next_rd     = pick(rd_mon_hit, mon) | pick(rd_mask_hit, mask) |
                                     pick(rd_clr_hit, clr_reg) | rd_grp;

  // registered read data keeps the output straight from a flop
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
    end else begin
      RD_DATA <= next_rd;
    end
  end

  // checks
  property p_mask_write;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (WR.en && WR.addr == MASK_BASE) |=> (mask[7:0] == $past(WR.data));
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask byte not written");

  property p_any_or;
    @(posedge SYS_CLK) disable iff (!RST_N)
    STATUS.any_irq == (|mon);
  endproperty
  a_any_or: assert property (p_any_or) else $error("any status differs from monitor OR");

  property p_group_or;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (STATUS.first_pair_group_status == (|mon[FIRST_LO*8 +: 40])) &&
    (STATUS.second_pair_group_status == (|mon[SECOND_LO*8 +: 40])) &&
    (STATUS.common_irq == (|mon[COMMON_LO*8 +: 40]));
  endproperty
  a_group_or: assert property (p_group_or) else $error("group status differs from monitor OR");

  property p_first_member;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (|qual[FIRST_LO*8 +: 40]) |=> STATUS.first_pair_group_status;
  endproperty
  a_first_member: assert property (p_first_member) else $error("first pair event lost");

  property p_second_member;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (|qual[SECOND_LO*8 +: 40]) |=> STATUS.second_pair_group_status;
  endproperty
  a_second_member: assert property (p_second_member) else $error("second pair event lost");

  property p_common_member;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (|qual[COMMON_LO*8 +: 40]) |=> STATUS.common_irq;
  endproperty
  a_common_member: assert property (p_common_member) else $error("common event lost");

  property p_sticky;
    @(posedge SYS_CLK) disable iff (!RST_N)
    1'b1 |=> ((mon & $past(mon & ~clr_vec)) == $past(mon & ~clr_vec));
  endproperty
  a_sticky: assert property (p_sticky) else $error("monitor bit dropped without clear");

  property p_set_cause;
    @(posedge SYS_CLK) disable iff (!RST_N)
    1'b1 |=> ((mon & ~$past(mon) & ~$past(qual)) == '0);
  endproperty
  a_set_cause: assert property (p_set_cause) else $error("monitor set without qualified event");

  property p_mask_reset;
    @(posedge SYS_CLK)
    $rose(RST_N) |-> (mask == '0);
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not zero after reset");

  property p_set_wins;
    @(posedge SYS_CLK) disable iff (!RST_N)
    1'b1 |=> ((mon & $past(qual)) == $past(qual));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("qualified event not recorded");

  property p_clr_self;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (clr_reg != '0 && wr_clr_hit == '0) |=> (clr_reg == '0);
  endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear bit did not self clear");

  property p_grp_all;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (wr_grp_hit && WR.data[GC_ALL]) |=> ##1 ((mon & ~$past(qual)) == '0);
  endproperty
  a_grp_all: assert property (p_grp_all) else $error("group clear all failed");

  property p_pin_clr;
    @(posedge SYS_CLK) disable iff (!RST_N)
    pin_clr[GC_ALL] |=> ((mon & ~$past(qual)) == '0);
  endproperty
  a_pin_clr: assert property (p_pin_clr) else $error("pin clear failed");

  // a written clear bit empties its monitor bit unless the event is still there
  property p_clr_bit;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (clr_reg != '0) |=> ((mon & $past(clr_reg) & ~$past(qual)) == '0);
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("clear bit left monitor set");

  // partial group clears empty their own group's bytes unless the event is still there
  property p_grp_part;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (grp_clr[GC_COMMON] |=> ((mon[COMMON_LO*8 +: 40] & ~$past(qual[COMMON_LO*8 +: 40])) == '0)) and
    (grp_clr[GC_FIRST]  |=> ((mon[FIRST_LO*8 +: 40]  & ~$past(qual[FIRST_LO*8 +: 40]))  == '0)) and
    (grp_clr[GC_SECOND] |=> ((mon[SECOND_LO*8 +: 40] & ~$past(qual[SECOND_LO*8 +: 40])) == '0));
  endproperty
  a_grp_part: assert property (p_grp_part) else $error("group clear by register failed");

  // pin clears per group behave like the register bits
  property p_pin_grp;
    @(posedge SYS_CLK) disable iff (!RST_N)
    (pin_clr[GC_COMMON] |=> ((mon[COMMON_LO*8 +: 40] & ~$past(qual[COMMON_LO*8 +: 40])) == '0)) and
    (pin_clr[GC_FIRST]  |=> ((mon[FIRST_LO*8 +: 40]  & ~$past(qual[FIRST_LO*8 +: 40]))  == '0)) and
    (pin_clr[GC_SECOND] |=> ((mon[SECOND_LO*8 +: 40] & ~$past(qual[SECOND_LO*8 +: 40])) == '0));
  endproperty
  a_pin_grp: assert property (p_pin_grp) else $error("group clear by pin failed");

  // a monitor bit can only rise where its mask was open
  property p_mask_block;
    @(posedge SYS_CLK) disable iff (!RST_N)
    1'b1 |=> ((mon & ~$past(mon) & ~$past(mask)) == '0);
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked event reached monitor");

  c_any_rise: cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(STATUS.any_irq));
  c_clr_fall: cover property (@(posedge SYS_CLK) disable iff (!RST_N) (clr_reg != '0) ##1 $fell(STATUS.any_irq));
  c_grp_clr:  cover property (@(posedge SYS_CLK) disable iff (!RST_N) wr_grp_hit ##2 !STATUS.any_irq);
  c_pin_clr:  cover property (@(posedge SYS_CLK) disable iff (!RST_N) $rose(pin_clr[GC_FIRST]));
  c_clr_race: cover property (@(posedge SYS_CLK) disable iff (!RST_N) ((clr_vec & qual) != '0));

endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the event monitor, mask and clear block
// assumes eim_pkg is compiled first and the block guards its own ports with assertions
`timescale 1ns/10ps
`default_nettype none
module tb;
  import eim_pkg::*;

  localparam logic [NUM_BITS-1:0] ONE = NUM_BITS'(1);

  // design ports
  logic                SYS_CLK;
  logic                RST_N;
  eim_wr_t             WR;
  logic [15:0]         RD_ADDR;
  logic [7:0]          RD_DATA;
  logic [NUM_BITS-1:0] EVT_RAW;
  logic [3:0]          MF_CLR;
  eim_status_t         STATUS;
  // bookkeeping
  int                  fails;
  int                  compares;

  eim_top DUT (
    .SYS_CLK (SYS_CLK),
    .RST_N   (RST_N),
    .WR      (WR),
    .RD_ADDR (RD_ADDR),
    .RD_DATA (RD_DATA),
    .EVT_RAW (EVT_RAW),
    .MF_CLR  (MF_CLR),
    .STATUS  (STATUS)
  );

  // 40 MHz system clock
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end

  // move to just after a rising edge, where every input changes
  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic end_sim();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one write, then a quiet cycle so the strobe never toggles twice in a step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    WR = '{en: 1'b1, addr: a, data: d};
    tick(1);
    WR = '{en: 1'b0, addr: 16'h0000, data: 8'h00};
    tick(1);
  endtask

  // read lands on the same edge that samples the address
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
    RD_ADDR = a;
    tick(1);
    compares++;
    if (RD_DATA !== exp) begin
      fails++;
      $display("mismatch at %0t: read %h got %h exp %h", $time, a, RD_DATA, exp);
    end
  endtask

  task automatic chk_stat(input eim_status_t exp);
    compares++;
    if (STATUS !== exp) begin
      fails++;
      $display("mismatch at %0t: status got %b exp %b", $time, STATUS, exp);
    end
  endtask

  function automatic eim_status_t st(input logic c, input logic f, input logic s);
    eim_status_t r;
    r.any_irq                  = c | f | s;
    r.common_irq               = c;
    r.first_pair_group_status  = f;
    r.second_pair_group_status = s;
    return r;
  endfunction

  // raw event pulse long enough to pass the three-flop synchroniser
  task automatic pulse(input logic [NUM_BITS-1:0] b);
    EVT_RAW = b;
    tick(6);
    EVT_RAW = '0;
    tick(6);
  endtask

  // watchdog: the whole run needs roughly 630 cycles
  initial begin
    #200000;
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial begin
    RST_N    = 1'b0;
    WR       = '{en: 1'b0, addr: 16'h0000, data: 8'h00};
    RD_ADDR  = 16'h0000;
    EVT_RAW  = '0;
    MF_CLR   = 4'h0;
    fails    = 0;
    compares = 0;
    repeat (6) @(posedge SYS_CLK);
    #1;
    RST_N = 1'b1;
    tick(1);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    for (int k = 0; k < NUM_BYTES; k++) begin
      chk_rd(MASK_BASE + 16'(k), MASK_RST);
    end
    // closed mask keeps an active event out
    EVT_RAW[3] = 1'b1;
    tick(6);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    chk_rd(MON_BASE, 8'h00);
    // opening the mask on an event already high sets the monitor at once
    wr(MASK_BASE, 8'h08);
    tick(6);
    chk_stat(st(1'b1, 1'b0, 1'b0));
    chk_rd(MASK_BASE, 8'h08);
    // a clear while the event is still high must not lose it
    wr(CLR_BASE, 8'h08);
    tick(4);
    chk_rd(MON_BASE, 8'h08);
    EVT_RAW[3] = 1'b0;
    tick(6);
    chk_stat(st(1'b1, 1'b0, 1'b0));
    wr(CLR_BASE, 8'h08);
    tick(3);
    chk_rd(CLR_BASE, 8'h00);
    chk_rd(MON_BASE, 8'h00);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    // monitor bank is read-only, unmapped space reads zero
    wr(MON_BASE, 8'hff);
    chk_rd(MON_BASE, 8'h00);
    chk_rd(16'h4000, 8'h00);
    // every byte lands in its own group
    for (int k = 0; k < NUM_BYTES; k++) begin
      wr(MASK_BASE + 16'(k), 8'h80);
      pulse(ONE << (8 * k + 7));
      chk_stat(st(k <= COMMON_HI, k >= FIRST_LO && k <= FIRST_HI, k >= SECOND_LO));
      chk_rd(MON_BASE + 16'(k), 8'h80);
      wr(CLR_BASE + 16'(k), 8'h80);
      tick(3);
      chk_stat(st(1'b0, 1'b0, 1'b0));
    end
    // group holds until its last member is cleared
    pulse((ONE << 47) | (ONE << 79));
    wr(CLR_BASE + 16'(5), 8'h80);
    tick(3);
    chk_stat(st(1'b0, 1'b1, 1'b0));
    wr(CLR_BASE + 16'(9), 8'h80);
    tick(3);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    // each group clear, first by register and then by pin
    for (int m = 0; m < 2; m++) begin
      for (int d = 0; d < 4; d++) begin
        pulse((ONE << 7) | (ONE << 47) | (ONE << 87));
        chk_stat(st(1'b1, 1'b1, 1'b1));
        if (m == 0) begin
          wr(GRP_CLR_ADDR, 8'(1 << d));
        end else begin
          MF_CLR[d] = 1'b1;
          tick(6);
          MF_CLR = 4'h0;
        end
        tick(6);
        chk_stat(st(!(d == 0 || d == 1), !(d == 0 || d == 2), !(d == 0 || d == 3)));
        chk_rd(GRP_CLR_ADDR, 8'h00);
        wr(GRP_CLR_ADDR, 8'h01);
        tick(3);
      end
    end
    // closing a mask again blocks its event
    wr(MASK_BASE, 8'h00);
    pulse(ONE << 7);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    // reset in mid-run brings the masks back to zero
    RST_N = 1'b0;
    tick(2);
    RST_N = 1'b1;
    tick(1);
    chk_rd(MASK_BASE + 16'(5), 8'h00);
    chk_stat(st(1'b0, 1'b0, 1'b0));
    end_sim();
  end

endmodule
`default_nettype wire
